// [core/stt_sample_buf.sv]
/*
  two-entry sample buffer with valid/ready on both sides.
  assumes a single clock and that flush empties it at once.
*/
module stt_sample_buf
  import stt_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  stt_buf_if.store bus
);
  logic [STT_SAMPLE_W-1:0] mem_reg [STT_BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;
  logic [1:0] count_next;

  // honest full and empty
  assign bus.in_ready = (count_reg != 2'h2);
  assign bus.out_valid = (count_reg != 2'h0);
  assign bus.out_data = mem_reg[rd_ptr_reg];
  assign push = bus.in_valid & bus.in_ready & ~bus.flush;
  assign pop = bus.out_valid & bus.out_ready & ~bus.flush;
  assign count_next = bus.flush ? 2'h0 : count_reg + {1'b0, push} - {1'b0, pop};

  // storage, one flop group per entry
  for (genvar i = 0; i < STT_BUF_DEPTH; i++)
  begin : g_entry
    always_ff @(posedge core_clk or negedge reset_n)
    begin
      if (!reset_n)
        mem_reg[i] <= '0;
      else if (push && wr_ptr_reg == 1'(i))
        mem_reg[i] <= bus.in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      wr_ptr_reg <= bus.flush ? 1'b0 : wr_ptr_reg ^ push;
      rd_ptr_reg <= bus.flush ? 1'b0 : rd_ptr_reg ^ pop;
      count_reg <= count_next;
    end
  end
endmodule

// [core/stt_spi_tunnel.sv]
/*
  spi tunnel endpoint: samples local spi pins into link words and
  regenerates spi pins from received link words, on either end of the link.
  assumes link words arrive on core_clk with a valid strobe; pins are async.
*/
// Operation
// - tunnel runs on the secondary lane, forward or reverse direction.
// - forward mode: master sits at serializer, data follows video.
// - reverse mode: master sits at deserializer, data against video.
// - tunnel never reaches local configuration registers; pass-through only.
// - serializer oversamples sclk, mosi, ss_n with the pixel clock.
// - each forward frame carries sclk, mosi and ss_n in own bits.
// - deserializer regenerates signals; mosi held while regenerated sclk high.
// - optional one-cycle delay of regenerated sclk behind mosi.
// - reverse: sample ss_n and sclk, capture mosi on active edge.
// - buffer reverse samples, send per frame, ss_n in every frame.
// - serializer replays reverse samples from buffer, possibly in bursts.
// - at most one data sample per back-channel frame.
module stt_spi_tunnel
  import stt_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [2:0] tunnel_mode_select_field,
  input wire logic role_is_deser,
  input wire logic clk_delay_en,
  input wire logic tunnel_serial_clock,
  input wire logic spi_mosi_in,
  input wire logic spi_ss_n_in,
  output logic link_tx_valid,
  output logic [STT_FRM_W-1:0] link_tx_frame,
  input wire logic link_rx_valid,
  input wire logic [STT_FRM_W-1:0] link_rx_frame,
  output logic spi_sclk_out,
  output logic spi_mosi_out,
  output logic spi_ss_n_out,
  output logic rev_buf_ready
);
  // synchronisers for pins and strap
  logic [STT_SYNC_W-1:0] sync1_reg;
  logic [STT_SYNC_W-1:0] sync2_reg;
  logic sclk_prev_reg;
  logic s_sclk;
  logic s_mosi;
  logic s_ss_n;
  logic s_deser;
  logic sclk_rise;

  // mode decode
  logic fwd_mode;
  logic rev_mode;
  logic ser_fwd;
  logic des_fwd;
  logic ser_rev;
  logic des_rev;

  // back-channel frame timer
  logic [STT_BC_CNT_W-1:0] frame_cnt_reg;
  logic frame_tick;

  // link transmit
  logic link_tx_valid_reg;
  logic [STT_FRM_W-1:0] link_tx_frame_reg;
  logic tx_valid_next;
  logic [STT_FRM_W-1:0] tx_frame_next;
  logic rev_buf_ready_reg;

  // regeneration
  logic sclk_out_reg;
  logic mosi_out_reg;
  logic ss_n_out_reg;
  logic sclk_next;
  logic mosi_next;
  logic ss_n_next;
  logic rx_sclk_d_reg;
  logic rx_sclk;
  logic rx_mosi;
  logic rx_ss_n;
  logic fwd_sclk;
  logic pend_valid_reg;
  logic pend_bit_reg;
  logic pend_valid_next;
  logic pend_bit_next;
  logic pend_take;
  stt_regen_t rg_state_reg;
  stt_regen_t rg_state_next;
  logic [STT_HALF_CNT_W-1:0] half_cnt_reg;
  logic [STT_HALF_CNT_W-1:0] half_cnt_next;
  logic half_done;

  // sample carrier and its two-entry store; flushed whenever this end
  // is not the reverse-mode sampler, so stale bits never leak into a new session
  stt_buf_if sbuf ();

  stt_sample_buf stt_sample_buf_inst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .bus(sbuf.store)
  );

  // two flops on every spi input pin; the role strap rides along so that
  // role and pin samples always belong to the same clock edge
  // sclk_prev resets low to match the idle pin level: no false edge after reset
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= STT_SYNC_RST;
      sync2_reg <= STT_SYNC_RST;
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {role_is_deser, spi_ss_n_in, spi_mosi_in, tunnel_serial_clock};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg[STT_SY_SCLK];
    end
  end

  assign s_sclk = sync2_reg[STT_SY_SCLK];
  assign s_mosi = sync2_reg[STT_SY_MOSI];
  assign s_ss_n = sync2_reg[STT_SY_SS];
  assign s_deser = sync2_reg[STT_SY_ROLE];
  assign sclk_rise = s_sclk & ~sclk_prev_reg;

  // mode and role decode; other field codes leave the tunnel idle
  // the field is written by host logic on this clock, so it needs no synchroniser
  assign fwd_mode = (tunnel_mode_select_field == STT_MODE_FWD);
  assign rev_mode = (tunnel_mode_select_field == STT_MODE_REV);
  assign ser_fwd = fwd_mode & ~s_deser;
  assign des_fwd = fwd_mode & s_deser;
  assign ser_rev = rev_mode & ~s_deser;
  assign des_rev = rev_mode & s_deser;

  // frame timer only runs while sending back-channel frames
  // one tick per 750 cycles, the slowest back-channel frame rate; the master
  // must hold ss_n high at least this long between transfers
  assign frame_tick = des_rev & (frame_cnt_reg == STT_BC_LAST);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      frame_cnt_reg <= '0;
    else if (!des_rev || frame_tick)
      frame_cnt_reg <= '0;
    else
      frame_cnt_reg <= frame_cnt_reg + 1'b1;
  end

  // reverse capture: mosi taken on rising sclk while selected
  // a bit that arrives while two wait is dropped; rev_buf_ready warns the master
  // one bit leaves per frame tick, never more
  assign sbuf.in_valid = des_rev & sclk_rise & ~s_ss_n;
  assign sbuf.in_data = s_mosi;
  assign sbuf.out_ready = frame_tick;
  assign sbuf.flush = ~des_rev;

  // link word: forward every cycle, reverse once per frame
  // in reverse the clock bit marks a carried sample instead of the pin level
  // pin samples only; no path reaches configuration state
  assign tx_valid_next = ser_fwd | frame_tick;
  assign tx_frame_next = ser_fwd ? {s_ss_n, s_sclk, s_mosi} :
                         frame_tick ? {s_ss_n, sbuf.out_valid, sbuf.out_data} :
                         STT_FRM_IDLE;

  // link output flops; the idle word shows ss_n high
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_tx_valid_reg <= 1'b0;
      link_tx_frame_reg <= STT_FRM_IDLE;
      rev_buf_ready_reg <= 1'b0;
    end
    else
    begin
      link_tx_valid_reg <= tx_valid_next;
      link_tx_frame_reg <= tx_frame_next;
      rev_buf_ready_reg <= des_rev & sbuf.in_ready;
    end
  end

  // received word fields
  // the delayed sclk copy follows only valid words, so the delay is one word
  assign rx_ss_n = link_rx_frame[STT_FRM_SS_BIT];
  assign rx_sclk = link_rx_frame[STT_FRM_CLK_BIT];
  assign rx_mosi = link_rx_frame[STT_FRM_DAT_BIT];
  assign fwd_sclk = clk_delay_en ? rx_sclk_d_reg : rx_sclk;

  // reverse replay: one pending sample, new arrival wins over consume
  // words come a frame apart while one replayed bit takes about nine cycles,
  // so an overwrite only happens if the far end breaks its own spacing
  assign half_done = (half_cnt_reg == STT_HALF_LAST);
  assign pend_take = (rg_state_reg == STT_RG_IDLE) & pend_valid_reg & ~ss_n_out_reg;
  assign pend_valid_next = (ser_rev & link_rx_valid & rx_sclk) |
                           (pend_valid_reg & ~pend_take & ser_rev);
  assign pend_bit_next = (ser_rev & link_rx_valid & rx_sclk) ? rx_mosi : pend_bit_reg;

  // regenerated pin values for both directions
  // forward: pins follow each valid word; mosi only moves while both the old
  // and the new sclk are low, which keeps it steady across the high phase
  // reverse: mosi first, a setup half, then a high half of sclk
  // any other mode or role parks sclk low and ss_n high
  always_comb
  begin
    rg_state_next = rg_state_reg;
    half_cnt_next = '0;
    sclk_next = 1'b0;
    mosi_next = mosi_out_reg;
    ss_n_next = 1'b1;
    if (des_fwd)
    begin
      ss_n_next = link_rx_valid ? rx_ss_n : ss_n_out_reg;
      sclk_next = link_rx_valid ? fwd_sclk : sclk_out_reg;
      if (link_rx_valid && !sclk_out_reg && !fwd_sclk)
        mosi_next = rx_mosi;
      rg_state_next = STT_RG_IDLE;
    end
    else if (ser_rev)
    begin
      ss_n_next = (link_rx_valid && !rx_ss_n) ? 1'b0 :
                  (link_rx_valid ? 1'b1 : ss_n_out_reg);
      sclk_next = sclk_out_reg;
      case (rg_state_reg)
        STT_RG_IDLE:
        begin
          if (pend_take)
          begin
            mosi_next = pend_bit_reg;
            rg_state_next = STT_RG_SETUP;
          end
        end
        STT_RG_SETUP:
        begin
          half_cnt_next = half_done ? '0 : half_cnt_reg + 1'b1;
          if (half_done)
          begin
            sclk_next = 1'b1;
            rg_state_next = STT_RG_HIGH;
          end
        end
        STT_RG_HIGH:
        begin
          half_cnt_next = half_done ? '0 : half_cnt_reg + 1'b1;
          if (half_done)
          begin
            sclk_next = 1'b0;
            rg_state_next = STT_RG_IDLE;
          end
        end
        default:
        begin
          sclk_next = 1'b0;
          rg_state_next = STT_RG_IDLE;
        end
      endcase
    end
    else
      rg_state_next = STT_RG_IDLE;
  end

  // regeneration registers
  // reset levels match idle spi pins: sclk low, ss_n high
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_out_reg <= 1'b0;
      mosi_out_reg <= 1'b0;
      ss_n_out_reg <= 1'b1;
      rx_sclk_d_reg <= 1'b0;
      pend_valid_reg <= 1'b0;
      pend_bit_reg <= 1'b0;
      rg_state_reg <= STT_RG_IDLE;
      half_cnt_reg <= '0;
    end
    else
    begin
      sclk_out_reg <= sclk_next;
      mosi_out_reg <= mosi_next;
      ss_n_out_reg <= ss_n_next;
      rx_sclk_d_reg <= link_rx_valid ? rx_sclk : rx_sclk_d_reg;
      pend_valid_reg <= pend_valid_next;
      pend_bit_reg <= pend_bit_next;
      rg_state_reg <= rg_state_next;
      half_cnt_reg <= half_cnt_next;
    end
  end

  // every output comes straight from a flop
  assign link_tx_valid = link_tx_valid_reg;
  assign link_tx_frame = link_tx_frame_reg;
  assign spi_sclk_out = sclk_out_reg;
  assign spi_mosi_out = mosi_out_reg;
  assign spi_ss_n_out = ss_n_out_reg;
  assign rev_buf_ready = rev_buf_ready_reg;
endmodule

// [include/stt_buf_if.sv]
/*
  valid/ready carrier between the sampler and its two-entry buffer.
  assumes both sides share one clock.
*/
interface stt_buf_if;
  import stt_pkg::*;
  logic in_valid;
  logic in_ready;
  logic [STT_SAMPLE_W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [STT_SAMPLE_W-1:0] out_data;
  logic flush;

  modport store (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready, input flush);
  modport user (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready, output flush);
endinterface

// [include/stt_pkg.sv]
/*
  constants shared by the spi tunnel block: mode codes, frame layout,
  reset values and cycle counts.
  assumes a 100 MHz core clock that also serves as pixel and oscillator clock.
*/
package stt_pkg;
  // tunnel mode codes carried by the mode select field
  localparam logic [2:0] STT_MODE_FWD = 3'h6;
  localparam logic [2:0] STT_MODE_REV = 3'h7;

  // clock and timing
  localparam int STT_CLK_PERIOD_NS = 10;
  localparam int STT_BC_FRAME_NS = 7500;
  localparam int STT_BC_FRAME_CYC = STT_BC_FRAME_NS / STT_CLK_PERIOD_NS;
  localparam int STT_REGEN_HALF_NS = 40;
  localparam int STT_REGEN_HALF_CYC =
    (STT_REGEN_HALF_NS + STT_CLK_PERIOD_NS - 1) / STT_CLK_PERIOD_NS;
  localparam int STT_BC_CNT_W = 10;
  localparam int STT_HALF_CNT_W = 4;
  localparam logic [STT_BC_CNT_W-1:0] STT_BC_LAST =
    STT_BC_CNT_W'(STT_BC_FRAME_CYC - 1);
  localparam logic [STT_HALF_CNT_W-1:0] STT_HALF_LAST =
    STT_HALF_CNT_W'(STT_REGEN_HALF_CYC - 1);

  // frame layout: three bits per link word
  localparam int STT_FRM_W = 3;
  localparam int STT_FRM_SS_BIT = 2;
  localparam int STT_FRM_CLK_BIT = 1;
  localparam int STT_FRM_DAT_BIT = 0;
  localparam logic [STT_FRM_W-1:0] STT_FRM_IDLE = 3'h4;

  // sample buffer
  localparam int STT_BUF_DEPTH = 2;
  localparam int STT_SAMPLE_W = 1;

  // synchroniser vector: role, ss_n, mosi, sclk
  localparam int STT_SYNC_W = 4;
  localparam int STT_SY_SCLK = 0;
  localparam int STT_SY_MOSI = 1;
  localparam int STT_SY_SS = 2;
  localparam int STT_SY_ROLE = 3;
  localparam logic [STT_SYNC_W-1:0] STT_SYNC_RST = 4'h4;

  typedef enum logic [1:0] {STT_RG_IDLE, STT_RG_SETUP, STT_RG_HIGH} stt_regen_t;
endpackage

// [tb/spi_tunnel_over_serial_link_tb.sv]
/*
  self-checking bench for the tunnel endpoint: all four role and mode pairs.
  assumes the far end model and the bound checker.
*/
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module spi_tunnel_over_serial_link_tb;
  import stt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset_n, role_is_deser, clk_delay_en, sclk, sclk_rnd, sclk_run, mosi, ss_n;
  logic req, busy, rx_valid, tx_valid, sclk_out, mosi_out, ss_n_out, buf_ready, sclk_prev, b;
  logic [2:0] mode;
  logic [STT_FRM_W-1:0] word, rx_frame, tx_frame, exp_v;
  logic [STT_FRM_W-1:0] exp_q[$];
  logic [31:0] seed = 32'hbb215514;
  int err_total, check_count;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic timed_out();
    err_total++;
    $display("[ERR] wait expected done seen timeout");
    end_of_test();
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge core_clk);
  endtask
  // hand one word to the far end once it is free
  task automatic send(logic [2:0] w);
    int i;
    for (i = 0; i < 100 && busy; i++) @(negedge core_clk);
    if (busy) timed_out();
    req = 1'b1;
    word = w;
    @(negedge core_clk);
    req = 1'b0;
  endtask
  task automatic wait_frame();
    int i;
    for (i = 0; i < 1000 && tx_valid !== 1'b1; i++) @(negedge core_clk);
    if (tx_valid !== 1'b1) timed_out();
    tick(1);
  endtask

  stt_spi_tunnel stt_spi_tunnel_inst (.core_clk(core_clk), .reset_n(reset_n),
    .tunnel_mode_select_field(mode), .role_is_deser(role_is_deser), .clk_delay_en(clk_delay_en),
    .tunnel_serial_clock(sclk_run ? sclk : sclk_rnd), .spi_mosi_in(mosi), .spi_ss_n_in(ss_n),
    .link_tx_valid(tx_valid), .link_tx_frame(tx_frame), .link_rx_valid(rx_valid),
    .link_rx_frame(rx_frame), .spi_sclk_out(sclk_out), .spi_mosi_out(mosi_out),
    .spi_ss_n_out(ss_n_out), .rev_buf_ready(buf_ready));
  stt_far_end stt_far_end_inst (.core_clk(core_clk), .reset_n(reset_n), .req(req),
    .word(word), .busy(busy), .link_rx_valid(rx_valid), .link_rx_frame(rx_frame));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // slow spi clock, runs only inside a transfer
  initial
  begin
    sclk = 1'b0;
    #3;
    forever #40 sclk = sclk_run ? ~sclk : 1'b0;
  end
  // compare each result against the oldest note, away from the launching edge
  always @(negedge core_clk)
  begin
    sclk_prev <= sclk_out;
    if ((role_is_deser && mode == STT_MODE_REV && tx_valid && tx_frame[1]) ||
        (!role_is_deser && mode == STT_MODE_REV && sclk_out && !sclk_prev))
    begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 3'h7;
      `CHK("result", exp_v, role_is_deser ? tx_frame : {ss_n_out, sclk_out, mosi_out})
    end
  end
  initial
  begin
    reset_n = 1'b0;
    {role_is_deser, clk_delay_en, sclk_rnd, sclk_run, mosi, req, mode, word} = '0;
    ss_n = 1'b1;
    err_total = 0;
    check_count = 0;
    tick(5);
    reset_n = 1'b1;
    // every other mode code keeps outputs quiet
    for (int m = 0; m < 6; m++)
    begin
      mode = 3'(m);
      tick(4);
      `CHK("idle ss_n_out", 1'b1, ss_n_out)
      `CHK("idle tx_valid", 1'b0, tx_valid)
    end
    $display("test idle_modes done");
    // forward sampler with random pins; the words are judged by the checker
    mode = STT_MODE_FWD;
    repeat (60)
    begin
      {ss_n, sclk_rnd, mosi} = 3'(xs());
      tick(1);
    end
    `CHK("fwd tx_valid", 1'b1, tx_valid)
    $display("test fwd_sample done");
    // forward regeneration from random words
    {ss_n, sclk_rnd} = 2'b10;
    role_is_deser = 1'b1;
    repeat (40)
    begin
      clk_delay_en = 1'(xs());
      send(3'(xs()));
    end
    $display("test fwd_regen done");
    // reverse sampler: three bits right after a frame, buffer holds two
    mode = STT_MODE_REV;
    tick(760); // select idle a full frame first
    ss_n = 1'b0;
    wait_frame();
    sclk_run = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      mosi = 1'(xs());
      if (i < 2) exp_q.push_back({2'b01, mosi});
      @(posedge sclk);
      @(negedge sclk);
      @(negedge core_clk);
    end
    sclk_run = 1'b0;
    tick(4);
    `CHK("buffer full", 1'b0, buf_ready)
    repeat (3) wait_frame();
    `CHK("rev samples left", 0, exp_q.size())
    ss_n = 1'b1;
    tick(760);
    $display("test rev_sample done");
    // reverse regeneration: select first, then one bit per word
    role_is_deser = 1'b0;
    tick(4);
    send(3'h0);
    repeat (6)
    begin
      b = 1'(xs());
      exp_q.push_back({2'b01, b});
      send({2'b01, b});
    end
    send(STT_FRM_IDLE);
    tick(20);
    `CHK("regen bits left", 0, exp_q.size())
    $display("test rev_regen done");
    end_of_test();
  end
endmodule

// [tb/stt_far_end.sv]
/*
  far link end model: sends one link word per request, then waits a gap.
  assumes the tunnel's core_clk; words are at least 18 cycles apart, far closer than back-channel frames.
*/
module stt_far_end
  import stt_pkg::*;
#(
  parameter int GAP = 16
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic req,
  input wire logic [STT_FRM_W-1:0] word,
  output logic busy,
  output logic link_rx_valid,
  output logic [STT_FRM_W-1:0] link_rx_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap_cnt;

  // one word per slot; afterwards the line shows the inverse of the last word
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gap_cnt <= 0;
      link_rx_valid <= 1'b0;
      link_rx_frame <= STT_FRM_IDLE;
    end
    else if (link_rx_valid)
    begin
      link_rx_valid <= 1'b0;
      link_rx_frame <= ~link_rx_frame; // stale word never shown
    end
    else if (gap_cnt != 0)
      gap_cnt <= gap_cnt - 1;
    else if (req)
    begin
      link_rx_valid <= 1'b1;
      link_rx_frame <= word;
      gap_cnt <= GAP;
    end
  end
  assign busy = link_rx_valid || gap_cnt != 0;
endmodule

// [tb/stt_spi_tunnel_checker.sv]
/*
  concurrent checks on the tunnel endpoint ports.
  assumes binding to stt_spi_tunnel; one clock domain.
*/
module stt_spi_tunnel_checker
  import stt_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [2:0] tunnel_mode_select_field,
  input wire logic role_is_deser,
  input wire logic clk_delay_en,
  input wire logic tunnel_serial_clock,
  input wire logic spi_mosi_in,
  input wire logic spi_ss_n_in,
  input wire logic link_tx_valid,
  input wire logic [STT_FRM_W-1:0] link_tx_frame,
  input wire logic link_rx_valid,
  input wire logic [STT_FRM_W-1:0] link_rx_frame,
  input wire logic spi_sclk_out,
  input wire logic spi_mosi_out,
  input wire logic spi_ss_n_out,
  input wire logic rev_buf_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // last sclk level carried by a valid word, for the delayed-clock check
  logic last_rx_sclk;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      last_rx_sclk <= 1'b0;
    else if (link_rx_valid)
      last_rx_sclk <= link_rx_frame[1];
  end
  // role and mode held long enough for the synchronisers
  sequence s_in(logic r, logic [2:0] m);
    (role_is_deser == r && tunnel_mode_select_field == m) [*6];
  endsequence
  // one regenerated bit: clock high four cycles, data steady
  sequence s_pulse;
    (spi_sclk_out && $stable(spi_mosi_out)) [*4] ##1 !spi_sclk_out;
  endsequence
  AST_FWD_SAMPLE:
    assert property (s_in(1'b0, STT_MODE_FWD) |-> link_tx_valid && link_tx_frame ==
      {$past(spi_ss_n_in, 3), $past(tunnel_serial_clock, 3), $past(spi_mosi_in, 3)})
    else $error("forward word differs from pins");
  AST_FWD_SS:
    assert property (s_in(1'b1, STT_MODE_FWD) ##0 link_rx_valid
      |=> spi_ss_n_out == $past(link_rx_frame[2])) else $error("forward ss_n wrong");
  AST_FWD_SCLK:
    assert property (s_in(1'b1, STT_MODE_FWD) ##0 (link_rx_valid && !clk_delay_en)
      |=> spi_sclk_out == $past(link_rx_frame[1])) else $error("forward sclk wrong");
  AST_FWD_SCLK_DLY:
    assert property (s_in(1'b1, STT_MODE_FWD) ##0 (link_rx_valid && clk_delay_en)
      |=> spi_sclk_out == $past(last_rx_sclk)) else $error("delayed forward sclk wrong");
  AST_FWD_MOSI_HOLD:
    assert property (s_in(1'b1, STT_MODE_FWD) ##0 $changed(spi_mosi_out)
      |-> !spi_sclk_out && !$past(spi_sclk_out)) else $error("mosi moved with sclk high");
  AST_REV_PULSE:
    assert property (s_in(1'b0, STT_MODE_REV) ##0 $rose(spi_sclk_out) |-> s_pulse)
    else $error("reverse clock pulse shape wrong");
  AST_REV_SS:
    assert property (s_in(1'b0, STT_MODE_REV) ##0 link_rx_valid
      |=> spi_ss_n_out == $past(link_rx_frame[2])) else $error("reverse ss_n wrong");
  AST_REV_SS_CAUSE:
    assert property (s_in(1'b0, STT_MODE_REV) ##0 $fell(spi_ss_n_out)
      |-> $past(link_rx_valid && !link_rx_frame[2])) else $error("ss_n fell uncaused");
  AST_REV_TX_PULSE:
    assert property (s_in(1'b1, STT_MODE_REV) ##0 link_tx_valid |=> !link_tx_valid [*8])
    else $error("back frame strobe too long");
  AST_IDLE:
    assert property ((tunnel_mode_select_field != STT_MODE_FWD &&
      tunnel_mode_select_field != STT_MODE_REV) [*2]
      |-> !link_tx_valid && spi_ss_n_out && !rev_buf_ready) else $error("idle not quiet");
endmodule

bind stt_spi_tunnel stt_spi_tunnel_checker stt_spi_tunnel_checker_inst (
  .core_clk(core_clk), .reset_n(reset_n), .tunnel_mode_select_field(tunnel_mode_select_field),
  .role_is_deser(role_is_deser), .clk_delay_en(clk_delay_en),
  .tunnel_serial_clock(tunnel_serial_clock), .spi_mosi_in(spi_mosi_in),
  .spi_ss_n_in(spi_ss_n_in), .link_tx_valid(link_tx_valid), .link_tx_frame(link_tx_frame),
  .link_rx_valid(link_rx_valid), .link_rx_frame(link_rx_frame), .spi_sclk_out(spi_sclk_out),
  .spi_mosi_out(spi_mosi_out), .spi_ss_n_out(spi_ss_n_out), .rev_buf_ready(rev_buf_ready));
